// ==== adc_timing_pkg.sv ====
// Constants, register map and shared decoders for the conversion timing
// generator. Assumes a 20 MHz system clock and a plain register port.
package adc_timing_pkg;

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 20_000_000;

	// ------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_ADDR   = 8'h00;
	localparam logic [7:0] CONFIG_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;

	// ------------------------------------------------------------
	// Mode register fields
	// ------------------------------------------------------------
	localparam int MODE_COMP_BIT  = 0;
	localparam int MODE_PWR_LSB   = 1;
	localparam int MODE_DIV_LSB   = 3;
	localparam int MODE_RUN_BIT   = 7;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [1:0] PWR_RESET = 2'h0;

	// ------------------------------------------------------------
	// Config register fields
	// ------------------------------------------------------------
	localparam int CFG_TRIG_LSB   = 0;
	localparam int CFG_SCAN_BIT   = 2;
	localparam int CFG_ONESHOT_BIT = 3;
	localparam int CFG_RES8_BIT   = 4;
	localparam logic [1:0] TRIG_HW_NOWAIT = 2'h2;
	localparam logic [1:0] TRIG_HW_WAIT   = 2'h3;
	localparam logic [1:0] TRIG_RESET     = 2'h0;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int STAT_START_BIT  = 0;
	localparam int STAT_STAB_BIT   = 1;
	localparam int STAT_SAMPLE_BIT = 2;
	localparam int STAT_CONV_BIT   = 3;
	localparam int STAT_WAIT_BIT   = 4;
	localparam int STAT_CHAN_LSB   = 5;
	localparam int STAT_RUN_BIT    = 7;

	// ------------------------------------------------------------
	// Power modes, conversion-clock cycle counts and the trigger-wait start delay in system clocks
	// ------------------------------------------------------------
	localparam logic [1:0] PWR_NORMAL_1 = 2'h0;
	localparam logic [1:0] PWR_NORMAL_2 = 2'h1;
	localparam logic [1:0] PWR_LOWV_1   = 2'h2;
	localparam logic [1:0] PWR_LOWV_2   = 2'h3;
	localparam logic [4:0] TOTAL_MODE1  = 5'h13;
	localparam logic [4:0] TOTAL_MODE2  = 5'h11;
	localparam logic [4:0] SAMPLE_MODE1 = 5'h07;
	localparam logic [4:0] SAMPLE_MODE2 = 5'h05;
	localparam logic [4:0] RES8_SHORTEN = 5'h02;
	localparam logic [4:0] STAB_NORMAL  = 5'h08;
	localparam logic [4:0] STAB_LOWV    = 5'h02;
	localparam logic [5:0] START_HW_WAIT = 6'h01;

	// Last count of the prescaler, i.e. division ratio minus one.
	function automatic logic [5:0] div_last(input logic [2:0] sel);
		case (sel)
			3'h0:    div_last = 6'h3f;
			3'h1:    div_last = 6'h1f;
			3'h2:    div_last = 6'h0f;
			3'h3:    div_last = 6'h07;
			3'h4:    div_last = 6'h05;
			3'h5:    div_last = 6'h04;
			3'h6:    div_last = 6'h03;
			default: div_last = 6'h01;
		endcase
	endfunction

	// Start delay in system clocks for software and no-wait triggers.
	function automatic logic [5:0] start_delay(input logic [2:0] sel);
		case (sel)
			3'h0:    start_delay = 6'h3f;
			3'h1:    start_delay = 6'h1f;
			3'h2:    start_delay = 6'h0f;
			3'h3:    start_delay = 6'h07;
			3'h4:    start_delay = 6'h05;
			3'h5:    start_delay = 6'h04;
			3'h6:    start_delay = 6'h03;
			default: start_delay = 6'h01;
		endcase
	endfunction

endpackage

// ==== conv_clock_prescaler.sv ====
// Conversion clock prescaler: emits a one-cycle enable every N system
// clocks. Assumes enable is low whenever the prescaler must restart.
`timescale 1ns/10ps
module conv_clock_prescaler #(
	parameter int CNT_W = 6
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Control
	input  wire logic             enable,
	input  wire logic [2:0]       div_sel,
	// Conversion clock enable
	output logic                  tick
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} presc_t;

	presc_t q;
	presc_t d;
	logic [CNT_W-1:0] last;

	initial begin
		if (CNT_W < 6)
			$error("prescaler counter too narrow for division by 64");
	end

	assign last = CNT_W'(adc_timing_pkg::div_last(div_sel));

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// single cycle tick
	always_comb begin
		d = q;
		tick = 1'b0;
		if (!enable) begin
			d.cnt = '0;
		end else if (q.cnt == last) begin
			d.cnt = '0;
			tick = 1'b1;
		end else begin
			d.cnt = q.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

endmodule

// ==== adc_conversion_timing.sv ====
// Timing generator for a successive-approximation converter: start delay,
// reference stabilization, sampling and conversion phases.
// Assumes triggers come from logic on the same clock, one cycle wide.
`timescale 1ns/10ps

module adc_conversion_timing #(
	parameter int SCAN_CHANNELS = 4
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  address,
	input  wire logic [31:0] write_data,
	input  wire logic        write_strobe,
	input  wire logic        read_strobe,
	output logic      [31:0] read_data,
	// Hardware trigger
	input  wire logic        hw_trigger,
	// Converter timing outputs
	output logic             conv_clock_tick,
	output logic             comparator_on,
	output logic             stabilizing,
	output logic             sampling,
	output logic             converting,
	output logic             conversion_done,
	output logic      [1:0]  scan_channel
);

	initial begin
		if (SCAN_CHANNELS < 1 || SCAN_CHANNELS > 4)
			$error("scan channel count must be 1 to 4");
	end

	localparam logic [1:0] LAST_CHAN = 2'(SCAN_CHANNELS - 1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_TRIG,
		ST_START,
		ST_STAB,
		ST_SAMPLE,
		ST_CONVERT
	} phase_t;

	typedef struct packed {
		phase_t      st;
		logic        conversion_run;
		logic        comparator_enable;
		logic        clock_divide_select_msb;
		logic [1:0]  clock_divide_select_lsb;
		logic        power_mode_select_msb;
		logic        power_mode_select_lsb;
		logic [1:0]  trig_mode;
		logic        scan_mode;
		logic        one_shot;
		logic        res8;
		logic [5:0]  sys_cnt;
		logic [4:0]  fad_cnt;
		logic [1:0]  chan;
		logic        done;
		logic [31:0] rdata;
	} core_t;

	core_t q;
	core_t d;

	logic       tick;
	logic       presc_en;
	logic [2:0] div_sel;
	logic [1:0] pwr_mode;

	assign div_sel  = {q.clock_divide_select_msb, q.clock_divide_select_lsb};
	assign pwr_mode = {q.power_mode_select_msb, q.power_mode_select_lsb};
	assign presc_en = (q.st == ST_STAB) || (q.st == ST_SAMPLE) ||
	                  (q.st == ST_CONVERT);

	conv_clock_prescaler #(
		.CNT_W   (6)
	) u_presc (
		.clock   (clock),
		.rst     (rst),
		.enable  (presc_en),
		.div_sel (div_sel),
		.tick    (tick)
	);

	// ------------------------------------------------------------
	// Mode-dependent phase lengths
	// ------------------------------------------------------------
	logic       mode2;
	logic       lowv;
	logic       hw_wait;
	logic       hw_nowait;
	logic [4:0] samp_len;
	logic [4:0] conv_len;
	logic [4:0] stab_len;
	logic [5:0] delay_len;

	assign mode2 = (pwr_mode == adc_timing_pkg::PWR_NORMAL_2) ||
	               (pwr_mode == adc_timing_pkg::PWR_LOWV_2);
	assign lowv  = (pwr_mode == adc_timing_pkg::PWR_LOWV_1) ||
	               (pwr_mode == adc_timing_pkg::PWR_LOWV_2);

	assign hw_wait   = (q.trig_mode == adc_timing_pkg::TRIG_HW_WAIT);
	assign hw_nowait = (q.trig_mode == adc_timing_pkg::TRIG_HW_NOWAIT);

	assign samp_len = mode2 ? adc_timing_pkg::SAMPLE_MODE2
	                        : adc_timing_pkg::SAMPLE_MODE1;

	always_comb begin
		conv_len = (mode2 ? adc_timing_pkg::TOTAL_MODE2
		                  : adc_timing_pkg::TOTAL_MODE1) - samp_len;
		if (q.res8)
			conv_len = conv_len - adc_timing_pkg::RES8_SHORTEN;
	end

	assign stab_len = lowv ? adc_timing_pkg::STAB_LOWV
	                       : adc_timing_pkg::STAB_NORMAL;

	assign delay_len = hw_wait ? adc_timing_pkg::START_HW_WAIT
	                           : adc_timing_pkg::start_delay(div_sel);

	// ------------------------------------------------------------
	// Software access decode
	// ------------------------------------------------------------
	logic mode_wr;
	logic cfg_wr;
	logic wr_run;
	logic wr_comp;
	logic stopped;
	logic sw_start;
	logic sw_stop;
	logic trig_set;

	assign mode_wr = write_strobe && (address == adc_timing_pkg::MODE_ADDR);
	assign cfg_wr  = write_strobe && (address == adc_timing_pkg::CONFIG_ADDR);
	assign wr_run  = write_data[adc_timing_pkg::MODE_RUN_BIT];
	assign wr_comp = write_data[adc_timing_pkg::MODE_COMP_BIT];
	assign stopped = !q.conversion_run && !q.comparator_enable;

	// Run is taken only with the comparator already on; trigger-wait mode
	// sets run by hardware alone, so a software set there is dropped.
	assign sw_start = mode_wr && wr_run && !q.conversion_run &&
	                  q.comparator_enable && !hw_wait;
	assign sw_stop  = mode_wr && !wr_run;
	assign trig_set = (q.st == ST_IDLE) && hw_wait && hw_trigger &&
	                  q.comparator_enable && !q.conversion_run;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.rdata = '0;

		if (mode_wr && stopped) begin
			{d.clock_divide_select_msb, d.clock_divide_select_lsb} =
				write_data[adc_timing_pkg::MODE_DIV_LSB +: 3];
			{d.power_mode_select_msb, d.power_mode_select_lsb} =
				write_data[adc_timing_pkg::MODE_PWR_LSB +: 2];
		end
		if (mode_wr && !q.conversion_run)
			d.comparator_enable = wr_comp;
		if (cfg_wr && stopped) begin
			d.trig_mode = write_data[adc_timing_pkg::CFG_TRIG_LSB +: 2];
			d.scan_mode = write_data[adc_timing_pkg::CFG_SCAN_BIT];
			d.one_shot  = write_data[adc_timing_pkg::CFG_ONESHOT_BIT];
			d.res8      = write_data[adc_timing_pkg::CFG_RES8_BIT];
		end

		case (q.st)
			ST_IDLE: begin
				d.chan = 2'h0;
				d.sys_cnt = 6'h00;
				if (trig_set) begin
					d.conversion_run = 1'b1;
					d.st = ST_START;
				end else if (sw_start) begin
					d.conversion_run = 1'b1;
					d.st = hw_nowait ? ST_WAIT_TRIG : ST_START;
				end
			end
			ST_WAIT_TRIG: begin
				d.chan = 2'h0;
				d.sys_cnt = 6'h00;
				if (hw_trigger)
					d.st = ST_START;
			end
			ST_START: begin
				d.sys_cnt = q.sys_cnt + 6'h01;
				d.fad_cnt = 5'h00;
				if (q.sys_cnt == delay_len - 6'h01)
					d.st = hw_wait ? ST_STAB : ST_SAMPLE;
			end
			ST_STAB: begin
				if (tick) begin
					d.fad_cnt = q.fad_cnt + 5'h01;
					if (q.fad_cnt == stab_len - 5'h01) begin
						d.fad_cnt = 5'h00;
						d.st = ST_SAMPLE;
					end
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					d.fad_cnt = q.fad_cnt + 5'h01;
					if (q.fad_cnt == samp_len - 5'h01) begin
						d.fad_cnt = 5'h00;
						d.st = ST_CONVERT;
					end
				end
			end
			ST_CONVERT: begin
				if (tick) begin
					d.fad_cnt = q.fad_cnt + 5'h01;
					if (q.fad_cnt == conv_len - 5'h01) begin
						d.fad_cnt = 5'h00;
						d.done = 1'b1;
						if (q.scan_mode && q.chan != LAST_CHAN) begin
							d.chan = q.chan + 2'h1;
							d.st = ST_SAMPLE;
						end else begin
							d.chan = 2'h0;
							if (!q.one_shot) begin
								d.st = ST_SAMPLE;
							end else if (hw_nowait) begin
								d.st = ST_WAIT_TRIG;
							end else begin
								d.conversion_run = 1'b0;
								d.st = ST_IDLE;
							end
						end
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
				d.conversion_run = 1'b0;
			end
		endcase

		// A trigger that sets run beats a software clear in the same cycle.
		if (sw_stop && !trig_set) begin
			d.conversion_run = 1'b0;
			d.st = ST_IDLE;
			d.fad_cnt = 5'h00;
		end

		// ------------------------------------------------------------
		// Read data, valid in the cycle after the strobe
		// ------------------------------------------------------------
		if (read_strobe) begin
			case (address)
				adc_timing_pkg::MODE_ADDR: begin
					d.rdata[adc_timing_pkg::MODE_COMP_BIT] =
						q.comparator_enable;
					d.rdata[adc_timing_pkg::MODE_PWR_LSB +: 2] = pwr_mode;
					d.rdata[adc_timing_pkg::MODE_DIV_LSB +: 3] = div_sel;
					d.rdata[adc_timing_pkg::MODE_RUN_BIT] = q.conversion_run;
				end
				adc_timing_pkg::CONFIG_ADDR: begin
					d.rdata[adc_timing_pkg::CFG_TRIG_LSB +: 2] = q.trig_mode;
					d.rdata[adc_timing_pkg::CFG_SCAN_BIT] = q.scan_mode;
					d.rdata[adc_timing_pkg::CFG_ONESHOT_BIT] = q.one_shot;
					d.rdata[adc_timing_pkg::CFG_RES8_BIT] = q.res8;
				end
				adc_timing_pkg::STATUS_ADDR: begin
					d.rdata[adc_timing_pkg::STAT_START_BIT] =
						(q.st == ST_START);
					d.rdata[adc_timing_pkg::STAT_STAB_BIT] =
						(q.st == ST_STAB);
					d.rdata[adc_timing_pkg::STAT_SAMPLE_BIT] =
						(q.st == ST_SAMPLE);
					d.rdata[adc_timing_pkg::STAT_CONV_BIT] =
						(q.st == ST_CONVERT);
					d.rdata[adc_timing_pkg::STAT_WAIT_BIT] =
						(q.st == ST_WAIT_TRIG);
					d.rdata[adc_timing_pkg::STAT_CHAN_LSB +: 2] = q.chan;
					d.rdata[adc_timing_pkg::STAT_RUN_BIT] = q.conversion_run;
				end
				default: d.rdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
			q.st <= ST_IDLE;
			{q.clock_divide_select_msb, q.clock_divide_select_lsb} <=
				adc_timing_pkg::DIV_RESET;
			{q.power_mode_select_msb, q.power_mode_select_lsb} <=
				adc_timing_pkg::PWR_RESET;
			q.trig_mode <= adc_timing_pkg::TRIG_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign read_data       = q.rdata;
	assign conv_clock_tick = tick;
	assign comparator_on   = q.comparator_enable;
	assign stabilizing     = (q.st == ST_STAB);
	assign sampling        = (q.st == ST_SAMPLE);
	assign converting      = (q.st == ST_CONVERT);
	assign conversion_done = q.done;
	assign scan_channel    = q.chan;

endmodule

// ==== adc_timing_assertions.sv ====
// Port-level checker for the conversion timing generator.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module adc_timing_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  address,
	input wire logic        write_strobe,
	input wire logic        read_strobe,
	input wire logic [31:0] read_data,
	// Timing outputs
	input wire logic        conv_clock_tick,
	input wire logic        comparator_on,
	input wire logic        stabilizing,
	input wire logic        sampling,
	input wire logic        converting,
	input wire logic        conversion_done
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Tick counts per phase; a phase that ends by a stop is never judged.
	logic [4:0] stab_q;
	logic [4:0] samp_q;
	logic [4:0] conv_q;
	always_ff @(posedge clock) begin
		stab_q <= stabilizing ? stab_q + 5'(conv_clock_tick) : 5'h0;
		samp_q <= sampling ? samp_q + 5'(conv_clock_tick) : 5'h0;
		conv_q <= converting ? conv_q + 5'(conv_clock_tick) : 5'h0;
	end

	property p_tick_single; conv_clock_tick |=> !conv_clock_tick; endproperty
	a_tick_single: assert property (p_tick_single)
		else $error("conversion clock enable longer than one cycle");
	property p_phase_excl; $onehot0({stabilizing, sampling, converting});
	endproperty
	a_phase_excl: assert property (p_phase_excl)
		else $error("two timing phases active together");
	property p_samp_len; $fell(sampling) && converting |-> samp_q inside {7, 5};
	endproperty
	a_samp_len: assert property (p_samp_len)
		else $error("sampling tick count wrong");
	property p_conv_len;
		$fell(converting) && conversion_done |-> conv_q inside {12, 10};
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion tick count wrong");
	property p_stab_len; $fell(stabilizing) && sampling |-> stab_q inside {8, 2};
	endproperty
	a_stab_len: assert property (p_stab_len)
		else $error("stabilization tick count wrong");
	property p_done_cause; conversion_done |-> $past(converting); endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done without a conversion phase");
	property p_done_pulse; conversion_done |=> !conversion_done; endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than one cycle");
	property p_no_restab; conversion_done |-> !stabilizing; endproperty
	a_no_restab: assert property (p_no_restab)
		else $error("stabilization after a completed conversion");
	property p_read_idle; !$past(read_strobe) |-> read_data == 32'h0; endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read data outside the answer cycle");
	property p_comp_write;
		$changed(comparator_on) |->
			$past(write_strobe) && $past(address) == adc_timing_pkg::MODE_ADDR;
	endproperty
	a_comp_write: assert property (p_comp_write)
		else $error("comparator enable changed without a mode write");
endmodule

bind adc_conversion_timing adc_timing_checker adc_timing_checker_i (
	.clock(clock), .rst(rst), .address(address),
	.write_strobe(write_strobe), .read_strobe(read_strobe),
	.read_data(read_data), .conv_clock_tick(conv_clock_tick),
	.comparator_on(comparator_on), .stabilizing(stabilizing),
	.sampling(sampling), .converting(converting),
	.conversion_done(conversion_done)
);

// ==== trig_source.sv ====
// Hardware trigger source model: one-cycle trigger a set lag after request.
// Assumes the bench requests at most one trigger per run.
`timescale 1ns/10ps
module trig_source (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Control from the bench
	input  wire logic       request,
	input  wire logic [3:0] lag,
	// Trigger to the device
	output logic            hw_trigger
);
	logic [3:0] cnt_q;
	logic       armed_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			armed_q <= 1'b0;
			cnt_q <= 4'h0;
			hw_trigger <= 1'b0;
		end else begin
			hw_trigger <= armed_q && cnt_q == 4'h0;
			if (request) begin
				armed_q <= 1'b1;
				cnt_q <= lag;
			end else if (armed_q) begin
				if (cnt_q == 4'h0) armed_q <= 1'b0;
				else cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

// ==== adc_conversion_timing_bench.sv ====
// Self-checking bench for the conversion timing generator.
// Assumes a 20 MHz clock and the register map of the timing package.
`timescale 1ns/10ps
module adc_conversion_timing_bench;
	logic clock = 1'b0, rst = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] write_data = 32'h0, read_data;
	logic request = 1'b0, hw_trigger, conv_clock_tick, comparator_on;
	logic [3:0] lag = 4'h0;
	logic stabilizing, sampling, converting, conversion_done;
	logic [1:0] scan_channel;
	logic [31:0] v;
	int n_fail = 0, n_tests = 0, cyc = 0, d;
	integer seed = 33854;

	adc_conversion_timing adc_conversion_timing_i (.clock(clock), .rst(rst),
		.address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .hw_trigger(hw_trigger),
		.conv_clock_tick(conv_clock_tick), .comparator_on(comparator_on),
		.stabilizing(stabilizing), .sampling(sampling),
		.converting(converting), .conversion_done(conversion_done),
		.scan_channel(scan_channel));
	trig_source trig_source_i (.clock(clock), .rst(rst), .request(request),
		.lag(lag), .hw_trigger(hw_trigger));

	initial begin
		forever #25 clock = ~clock;
	end

	task test_done;
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			test_done;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge clock);
		address <= a;
		write_data <= dat;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] dat);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 dat = read_data;
	endtask

	function automatic int ratio(input logic [2:0] dv);
		int r[8] = '{64, 32, 16, 8, 6, 5, 4, 2};
		return r[dv];
	endfunction

	task run_conv(input logic [2:0] dv, input logic [1:0] pw, input logic r8,
		input logic [1:0] tg, input logic sc, input logic os);
		logic [31:0] m;
		int n, st, sa, co, f;
		m = {26'h0, dv, pw, 1'b1};
		sa = 0;
		// The first write stops a run; only then may the comparator go off.
		wr(adc_timing_pkg::MODE_ADDR, 32'h0);
		wr(adc_timing_pkg::MODE_ADDR, 32'h0);
		wr(adc_timing_pkg::CONFIG_ADDR, {27'h0, r8, os, sc, tg});
		wr(adc_timing_pkg::MODE_ADDR, m);
		// A field change with the comparator on must be refused.
		wr(adc_timing_pkg::MODE_ADDR, m ^ 32'h08);
		rd(adc_timing_pkg::MODE_ADDR, v);
		check(v, m);
		check(comparator_on, 1'b1);
		if (tg != 2'h3)
			wr(adc_timing_pkg::MODE_ADDR, m | 32'h80);
		// Hardware modes start at the edge that sees the trigger high.
		if (tg[1]) begin
			lag <= 4'($random(seed));
			request <= 1'b1;
			@(posedge clock);
			request <= 1'b0;
			do @(posedge clock); while (hw_trigger !== 1'b1);
		end
		n = 0;
		do begin @(posedge clock); #1 n++; end
			while (sampling !== 1'b1 && stabilizing !== 1'b1);
		check(n, (tg == 2'h3) ? 1 : ratio(dv) - 1);
		// A tick seen after an edge is taken at the next one.
		n = 0;
		do begin @(posedge clock); #1 n++; end while (conv_clock_tick !== 1'b1);
		check(n, ratio(dv) - 1);
		f = stabilizing;
		sa = sampling;
		for (int k = 0; k < (sc ? 4 : (os ? 1 : 2)); k++) begin
			st = (k == 0) ? f : 0;
			co = 0;
			do begin
				@(posedge clock);
				#1;
				if (conv_clock_tick === 1'b1) begin
					st += stabilizing;
					sa += sampling;
					co += converting;
				end
			end while (conversion_done !== 1'b1);
			check(st, (k == 0 && tg == 2'h3) ? (pw[1] ? 2 : 8) : 0);
			check(sa, pw[0] ? 5 : 7);
			check(co, 12 - 2 * r8);
			check(sampling, !os || (sc && k < 3));
			check(scan_channel, (sc && k < 3) ? k + 1 : 0);
			sa = 0;
		end
		rd(adc_timing_pkg::STATUS_ADDR, v);
		check(v[7], !os || tg == 2'h2);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(adc_timing_pkg::MODE_ADDR, v);
		check(v, 32'h0);
		rd(adc_timing_pkg::CONFIG_ADDR, v);
		check(v, 32'h0);
		rd(adc_timing_pkg::STATUS_ADDR, v);
		check(v, 32'h0);
		rd(8'h0c, v);
		check(v, 32'h0);
		// division by 64 is kept out at this clock rate
		for (d = 1; d < 8; d++) begin
			run_conv(3'(d), 2'(d), 1'($random(seed)), d[0] ? 2'h0 : 2'h2,
				d == 2, d != 3);
		end
		run_conv(3'(1 + $unsigned($random(seed)) % 7), {1'b0, 1'($random(seed))},
			1'($random(seed)), 2'h3, 1'b1, 1'b1);
		run_conv(3'(1 + $unsigned($random(seed)) % 7), {1'b1, 1'($random(seed))},
			1'($random(seed)), 2'h3, 1'b0, 1'b0);
		test_done;
	end
endmodule
